// *** core/swr_cfg.svh ***
// Purpose: offsets, field positions, codes and reset values of the stop wake block
// Assumes: 32-bit classic wishbone, one register per aligned word, byte address = 4 * index
// Notes: narrow registers sit in the low bits, upper bits read as zero
//
// Notes on behaviour
// - Source-select code 000 picks no gate, 001 the NAND of port 2 pins 3..0, 010 the NAND of port 2 pins 7..0.
// - Codes 011 to 110 pick NOR or NAND of port 3 pins 3..1, the last two also taking port 0 pins 0 and 7.
// - A recovery starts on an event from any one of the enabled wake sources.
// - The gate equations leave out every pin chosen in the first wake register or driven as an output.
// - The select and status registers keep their contents through a stop recovery; only rst_i or a bus write clears them.
// - Bit n (0..3) of the port-3 wake-select register enables port 3 pin n as a wake source.
// - Before any reference is latched, a selected port 3 pin wakes on a zero input level.
// - Once a pin is selected, each later read or write of the port data register latches its reference bit.
// - A selected port 3 pin wakes whenever its level differs from its latest reference bit.
// - The port-3 status field reads 00 with no access, 01 after a read and 10 after a write made while a pin is selected; 11 is reserved.
// - Software may write 00 to the port-3 status field to return to waking on a zero level.
// - The port-2 status field reads 00 with no access, 01 after a port 2 read and 10 after a write.
// - Wake events raise the second interrupt request only while the interrupt-enable bit is set.
// - A polarity bit chooses whether the selected gate output wakes on a low or a high level.
`ifndef SWR_CFG_SVH
`define SWR_CFG_SVH

`define SWR_IDX_STATUS 12'hf0a
`define SWR_IDX_GATESEL 12'hf0d
`define SWR_IDX_P3SEL 12'hf0e
`define SWR_IDX_EVT 12'hf10
`define SWR_IDX_MASK 12'hf11

`define SWR_GS_SRC_LSB 2
`define SWR_GS_POL_BIT 6
`define SWR_ST_P2_LSB 0
`define SWR_ST_P3_LSB 2
`define SWR_ST_IRQEN_BIT 4

`define SWR_REF_NONE 2'b00
`define SWR_REF_READ 2'b01
`define SWR_REF_WRITE 2'b10

`define SWR_SRC_NONE 3'b000
`define SWR_SRC_P2_LO 3'b001
`define SWR_SRC_P2_ALL 3'b010
`define SWR_SRC_P3_NOR 3'b011
`define SWR_SRC_P3_NAND 3'b100
`define SWR_SRC_P30_NOR 3'b101
`define SWR_SRC_P30_NAND 3'b110

`define SWR_RST_SRC 3'b000
`define SWR_RST_POL 1'b0
`define SWR_RST_P3SEL 4'h0
`define SWR_RST_STAT 2'b00

`endif

// *** core/swr_pkg.sv ***
// Purpose: shared types of the stop wake block
// Assumes: ports 0, 2 and 3 are eight pins wide
// Notes: none
package swr_pkg;

  typedef struct packed {
    logic [7:0] p0;
    logic [7:0] p2;
    logic [7:0] p3;
  } swr_pins_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] data;
  } swr_acc_s;

endpackage

// *** core/swr_gate_sel.sv ***
// Purpose: gate wake source, NAND or NOR of chosen pins, with polarity
// Assumes: pins already synchronised to clk_i
// Notes: trigger is registered, one cycle after the pins
`timescale 1ns/1ps
`include "swr_cfg.svh"
module swr_gate_sel
  import swr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire swr_pins_s pins_i,
  input wire swr_pins_s excl_i,
  input wire logic [2:0] src_i,
  input wire logic pol_i,
  output logic trig_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // excluded pins
  // excluded pins are forced to the value that leaves the gate unaffected
  wire [7:0] p2_and = pins_i.p2 | excl_i.p2;
  wire [2:0] p3_and = pins_i.p3[3:1] | excl_i.p3[3:1];
  wire [2:0] p3_or = pins_i.p3[3:1] & ~excl_i.p3[3:1];
  wire [1:0] p0_and = {pins_i.p0[7], pins_i.p0[0]} | {excl_i.p0[7], excl_i.p0[0]};
  wire [1:0] p0_or = {pins_i.p0[7], pins_i.p0[0]} & ~{excl_i.p0[7], excl_i.p0[0]};

  logic gate;
  logic active;
  always_comb begin
    gate = 1'b0;
    active = 1'b1;
    case (src_i)
      `SWR_SRC_P2_LO: gate = ~&p2_and[3:0];
      `SWR_SRC_P2_ALL: gate = ~&p2_and;
      `SWR_SRC_P3_NOR: gate = ~|p3_or;
      `SWR_SRC_P3_NAND: gate = ~&p3_and;
      `SWR_SRC_P30_NOR: gate = ~|{p3_or, p0_or};
      `SWR_SRC_P30_NAND: gate = ~&{p3_and, p0_and};
      default: active = 1'b0;
    endcase
  end

  wire nxt_trig = active & (gate ^ ~pol_i);

  logic trig_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_ff <= 1'b0;
    end else begin
      trig_ff <= nxt_trig;
    end
  end
  assign trig_o = trig_ff;

  a_src_none_quiet: assert property (src_i == `SWR_SRC_NONE |=> !trig_o)
    else $error("gate wake fired with no source selected");
  a_p2lo_nand_low: assert property (
    (src_i == `SWR_SRC_P2_LO && !pol_i && excl_i.p2[3:0] == 4'h0 && pins_i.p2[3:0] == 4'hf)
    |=> trig_o)
    else $error("p2 nand low output did not wake on low polarity");
endmodule

// *** core/swr_p3_cmp.sv ***
// Purpose: per-pin port 3 compare against latched reference
// Assumes: pins already synchronised to clk_i
// Notes: event is registered, one cycle after the pins
`timescale 1ns/1ps
`include "swr_cfg.svh"
module swr_p3_cmp
  import swr_pkg::*;
#(
  parameter int NPIN = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NPIN-1:0] pins_i,
  input wire logic [NPIN-1:0] sel_i,
  input wire logic [NPIN-1:0] ref_i,
  input wire logic [1:0] stat_i,
  output logic evt_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // zero level until a reference exists, then mismatch
  wire [NPIN-1:0] mism = (stat_i == `SWR_REF_NONE) ? ~pins_i : (pins_i ^ ref_i);
  wire nxt_evt = |(mism & sel_i);

  logic evt_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_ff <= 1'b0;
    end else begin
      evt_ff <= nxt_evt;
    end
  end
  assign evt_o = evt_ff;

  a_default_zero: assert property (
    (stat_i == `SWR_REF_NONE && sel_i[0] && !pins_i[0]) |=> evt_o)
    else $error("selected pin at zero without reference did not wake");
  a_unsel_quiet: assert property (sel_i == '0 |=> !evt_o)
    else $error("compare woke with no pin selected");
endmodule

// *** core/swr_top.sv ***
// Purpose: stop-mode wake source logic with wishbone register access
// Assumes: port data accesses arrive as same-clock pulses from the port block
// Notes: stop recovery itself never clears these registers, only rst_i or a bus write does
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "swr_cfg.svh"
module swr_top
  import swr_pkg::*;
#(
  parameter int AW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [AW-1:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire swr_pins_s pins_i,
  input wire swr_pins_s pin_out_en_i,
  input wire swr_pins_s first_sel_i,
  input wire swr_acc_s p2_acc_i,
  input wire swr_acc_s p3_acc_i,
  output logic wake_o,
  output logic second_irq_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  function automatic logic idx_hit(input logic [AW-1:0] adr, input logic [11:0] idx);
    idx_hit = (adr[AW-1:2] == (AW-2)'(idx));
  endfunction

  // write beats read: an access with both rd and wr set is taken as a write
  function automatic logic [1:0] acc_kind(input swr_acc_s acc);
    acc_kind = acc.wr ? `SWR_REF_WRITE : `SWR_REF_READ;
  endfunction

  // pin synchroniser, only the second stage is read
  swr_pins_s sync1_ff;
  swr_pins_s sync2_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pins_i;
      sync2_ff <= sync1_ff;
    end
  end

  // register state, declared ahead of the decode that reads it
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [2:0] src_ff;
  logic pol_ff;
  logic [3:0] p3sel_ff;
  logic irq_en_ff;
  logic [1:0] p3_stat_ff;
  logic [1:0] p2_stat_ff;
  logic [3:0] p3_ref_ff;
  logic [1:0] evt_ff;
  logic [1:0] mask_ff;
  logic wake_ff;

  // bus decode
  wire bus_req = cyc_i & stb_i;
  wire bus_commit = bus_req & ack_ff;
  wire wr_go = bus_commit & we_i & sel_i[0];
  wire hit_stat = idx_hit(adr_i, `SWR_IDX_STATUS);
  wire hit_gsel = idx_hit(adr_i, `SWR_IDX_GATESEL);
  wire hit_p3sel = idx_hit(adr_i, `SWR_IDX_P3SEL);
  wire hit_evt = idx_hit(adr_i, `SWR_IDX_EVT);
  wire hit_mask = idx_hit(adr_i, `SWR_IDX_MASK);
  wire wr_stat = wr_go & hit_stat;
  wire wr_gsel = wr_go & hit_gsel;
  wire wr_p3sel = wr_go & hit_p3sel;
  wire wr_evt = wr_go & hit_evt;
  wire wr_mask = wr_go & hit_mask;

  // single wait state, ack drops the cycle after it is given
  wire nxt_ack = bus_req & ~ack_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end
  assign ack_o = ack_ff;

  // write-only selects read as zero, unmapped reads answer zero
  wire [7:0] stat_rd = {3'b000, irq_en_ff, p3_stat_ff, p2_stat_ff};
  wire [31:0] nxt_dat = hit_stat ? {24'h0, stat_rd} :
                        hit_evt ? {30'h0, evt_ff} :
                        hit_mask ? {30'h0, mask_ff} : 32'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0;
    end else if (nxt_ack) begin
      dat_ff <= nxt_dat;
    end
  end
  assign dat_o = dat_ff;

  // select registers cleared only by rst_i or a bus write
  // reserved select bits are ignored on write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_ff <= `SWR_RST_SRC;
      pol_ff <= `SWR_RST_POL;
      p3sel_ff <= `SWR_RST_P3SEL;
    end else begin
      if (wr_gsel) begin
        src_ff <= dat_i[`SWR_GS_SRC_LSB +: 3];
        pol_ff <= dat_i[`SWR_GS_POL_BIT];
      end
      if (wr_p3sel) begin
        p3sel_ff <= dat_i[3:0];
      end
    end
  end

  // reference capture on selected pins only
  wire p3_acc = (p3_acc_i.rd | p3_acc_i.wr) & (|p3sel_ff);
  wire [3:0] nxt_ref = (p3_acc_i.data[3:0] & p3sel_ff) | (p3_ref_ff & ~p3sel_ff);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p3_ref_ff <= 4'h0;
    end else if (p3_acc) begin
      p3_ref_ff <= nxt_ref;
    end
  end

  // port-3 status, access wins over a software write
  wire [1:0] nxt_p3_stat = p3_acc ? acc_kind(p3_acc_i) :
                           wr_stat ? dat_i[`SWR_ST_P3_LSB +: 2] : p3_stat_ff;
  // port-2 status follows each port 2 access
  wire p2_acc = p2_acc_i.rd | p2_acc_i.wr;
  wire [1:0] nxt_p2_stat = p2_acc ? acc_kind(p2_acc_i) :
                           wr_stat ? dat_i[`SWR_ST_P2_LSB +: 2] : p2_stat_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p3_stat_ff <= `SWR_RST_STAT;
      p2_stat_ff <= `SWR_RST_STAT;
      irq_en_ff <= 1'b0;
    end else begin
      p3_stat_ff <= nxt_p3_stat;
      p2_stat_ff <= nxt_p2_stat;
      if (wr_stat) begin
        irq_en_ff <= dat_i[`SWR_ST_IRQEN_BIT];
      end
    end
  end

  // pins in the first register or driven out are left out
  swr_pins_s excl;
  assign excl = first_sel_i | pin_out_en_i;

  logic gate_trig;
  swr_gate_sel u_gate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i(sync2_ff),
    .excl_i(excl),
    .src_i(src_ff),
    .pol_i(pol_ff),
    .trig_o(gate_trig)
  );

  // output-driven port 3 pins never compare
  logic p3_trig;
  swr_p3_cmp #(
    .NPIN(4)
  ) u_p3 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i(sync2_ff.p3[3:0]),
    .sel_i(p3sel_ff & ~pin_out_en_i.p3[3:0]),
    .ref_i(p3_ref_ff),
    .stat_i(p3_stat_ff),
    .evt_o(p3_trig)
  );

  wire [1:0] evt_in = {p3_trig, gate_trig};
  wire nxt_wake = |evt_in;
  // sticky events, set wins over write-one-to-clear
  wire [1:0] nxt_evt = evt_in | (evt_ff & ~(wr_evt ? dat_i[1:0] : 2'b00));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_ff <= 1'b0;
      evt_ff <= 2'b00;
      mask_ff <= 2'b00;
    end else begin
      wake_ff <= nxt_wake;
      evt_ff <= nxt_evt;
      if (wr_mask) begin
        mask_ff <= dat_i[1:0];
      end
    end
  end
  assign wake_o = wake_ff;

  assign second_irq_o = irq_en_ff & (|(evt_ff & mask_ff));

  sequence s_req_open;
    bus_req && !ack_o;
  endsequence
  sequence s_ack_once;
    ack_o ##1 !ack_o;
  endsequence

  a_ack_timing: assert property (s_req_open |=> s_ack_once)
    else $error("wishbone ack not given once one cycle after request");
  a_wake_any: assert property ((gate_trig || p3_trig) |=> wake_o)
    else $error("enabled source event did not raise wake");
  a_wake_cause: assert property (wake_o |-> $past(gate_trig || p3_trig))
    else $error("wake raised without a source event");
  a_ref_capture: assert property (
    p3_acc |=> ((p3_ref_ff ^ $past(p3_acc_i.data[3:0])) & $past(p3sel_ff)) == 4'h0)
    else $error("selected reference bit not latched from port access");
  a_p3_stat_kind: assert property (
    p3_acc |=> p3_stat_ff == (($past(p3_acc_i.wr)) ? `SWR_REF_WRITE : `SWR_REF_READ))
    else $error("port-3 status does not match access kind");
  a_p3_sw_clear: assert property (
    (wr_stat && !p3_acc && dat_i[3:2] == 2'b00) |=> p3_stat_ff == `SWR_REF_NONE)
    else $error("software write of 00 did not clear port-3 status");
  a_p2_stat_kind: assert property (
    p2_acc |=> p2_stat_ff == (($past(p2_acc_i.wr)) ? `SWR_REF_WRITE : `SWR_REF_READ))
    else $error("port-2 status does not match access kind");
  a_irq_enable: assert property (second_irq_o |-> irq_en_ff)
    else $error("interrupt raised while enable clear");
  a_sel_kept: assert property ((!wr_gsel && !wr_p3sel) |=> $stable(src_ff) && $stable(p3sel_ff))
    else $error("select register changed without a bus write");
  a_evt_sticky: assert property ((evt_ff[0] && !wr_evt) |=> evt_ff[0])
    else $error("sticky event lost without a clear");

  // port 3 accesses as taken by the reference capture
  sequence s_p3_wr_taken;
    p3_acc && p3_acc_i.wr;
  endsequence
  sequence s_p3_rd_taken;
    p3_acc && !p3_acc_i.wr;
  endsequence

  a_ack_single: assert property (
    ack_o |=> !ack_o)
    else $error("wishbone ack held longer than one cycle");
  a_ack_needs_req: assert property (
    ack_o |-> $past(bus_req))
    else $error("wishbone ack given without a request");
  a_rd_status: assert property (
    (ack_o && !we_i && $past(hit_stat)) |-> dat_o == {24'h0, $past(stat_rd)})
    else $error("status read data differs from the status fields");
  a_rd_wo_zero: assert property (
    (ack_o && !we_i && $past(hit_gsel || hit_p3sel)) |-> dat_o == 32'h0)
    else $error("write-only select register read back nonzero");
  a_lane_ignored: assert property (
    (bus_commit && we_i && !sel_i[0]) |=> $stable(mask_ff) && $stable(irq_en_ff))
    else $error("write without byte lane zero changed a register");
  a_wake_quiet: assert property (
    (!gate_trig && !p3_trig) |=> !wake_o)
    else $error("wake raised with no source event");
  a_evt_gate_set: assert property (
    gate_trig |=> evt_ff[0])
    else $error("gate event not recorded");
  a_evt_p3_set: assert property (
    p3_trig |=> evt_ff[1])
    else $error("port 3 event not recorded");
  a_evt_clear: assert property (
    (wr_evt && dat_i[0] && !gate_trig) |=> !evt_ff[0])
    else $error("gate event not cleared by writing one");
  a_ref_kept: assert property (
    !p3_acc |=> $stable(p3_ref_ff))
    else $error("reference changed without a port 3 access");
  a_ref_unsel: assert property (
    p3_acc |=> ((p3_ref_ff ^ $past(p3_ref_ff)) & ~$past(p3sel_ff)) == 4'h0)
    else $error("unselected reference bit changed on access");
  a_p3_stat_hold: assert property (
    (!p3_acc && !wr_stat) |=> $stable(p3_stat_ff))
    else $error("port-3 status changed with no access or write");
  a_p2_stat_hold: assert property (
    (!p2_acc && !wr_stat) |=> $stable(p2_stat_ff))
    else $error("port-2 status changed with no access or write");
  a_p3_wr_status: assert property (
    s_p3_wr_taken |=> p3_stat_ff == `SWR_REF_WRITE)
    else $error("port 3 write not reported as write reference");
  a_p3_rd_status: assert property (
    s_p3_rd_taken |=> p3_stat_ff == `SWR_REF_READ)
    else $error("port 3 read not reported as read reference");
  a_irq_en_wr: assert property (
    wr_stat |=> irq_en_ff == $past(dat_i[`SWR_ST_IRQEN_BIT]))
    else $error("interrupt enable not taken from status write");
  a_irq_raise: assert property (
    (irq_en_ff && (evt_ff & mask_ff) != 2'b00) |-> second_irq_o)
    else $error("enabled unmasked event did not raise interrupt");
  a_src_wr: assert property (
    wr_gsel |=> src_ff == $past(dat_i[`SWR_GS_SRC_LSB +: 3]))
    else $error("source code not taken from gate select write");
  a_pol_wr: assert property (
    wr_gsel |=> pol_ff == $past(dat_i[`SWR_GS_POL_BIT]))
    else $error("polarity not taken from gate select write");
  a_p3sel_wr: assert property (
    wr_p3sel |=> p3sel_ff == $past(dat_i[3:0]))
    else $error("pin enables not taken from port-3 select write");
endmodule

// *** verif/swr_port_model.sv ***
// Purpose: port pins and port data accesses seen by the stop wake block
// Assumes: accesses are one-cycle pulses on clk_i
// Notes: idle access data shows the inverted last value, never a stale copy
`timescale 1ns/1ps
module swr_port_model
  import swr_pkg::*;
(
  input wire logic clk_i,
  output swr_pins_s pins_o,
  output swr_acc_s p2_acc_o,
  output swr_acc_s p3_acc_o
);
  initial begin
    pins_o = '1;
    p2_acc_o = '0;
    p3_acc_o = '0;
  end

  task automatic set_pins(input swr_pins_s v);
    @(posedge clk_i);
    pins_o <= v;
  endtask

  task automatic access(input logic p3, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    if (p3) begin
      p3_acc_o <= '{rd: !w, wr: w, data: d};
    end else begin
      p2_acc_o <= '{rd: !w, wr: w, data: d};
    end
    @(posedge clk_i);
    p2_acc_o <= '{rd: 1'b0, wr: 1'b0, data: ~d};
    p3_acc_o <= '{rd: 1'b0, wr: 1'b0, data: ~d};
  endtask
endmodule

// *** verif/tb.sv ***
// Purpose: self-checking bench of the stop wake block
// Assumes: ack comes within a few cycles of a request
// Notes: events are read back through the sticky event register
`timescale 1ns/1ps
`include "swr_cfg.svh"
module tb
  import swr_pkg::*;
;
  logic clk_i, rst_i, we, cyc, stb, ack, wake, irq;
  logic [15:0] adr;
  logic [31:0] wdat, dat, q;
  logic [3:0] sel;
  swr_pins_s pins, oen, fsel;
  swr_acc_s p2a, p3a;
  int n_mismatch, n_compared;
  swr_pins_s pat[6] = '{24'hffffff, 24'hffefff, 24'hfffeff, 24'hfffffb, 24'h7fffff,
    24'hffff00};

  swr_top dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .dat_o(dat),
    .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .pins_i(pins),
    .pin_out_en_i(oen), .first_sel_i(fsel), .p2_acc_i(p2a), .p3_acc_i(p3a),
    .wake_o(wake), .second_irq_o(irq));
  swr_port_model pm (.clk_i(clk_i), .pins_o(pins), .p2_acc_o(p2a), .p3_acc_o(p3a));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    n_compared++;
    if (seen !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task automatic wb(input logic [11:0] i, input logic w, input logic [7:0] d,
      input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= {2'b00, i, 2'b00};
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk("ack", {31'h0, ack}, 32'h1);
    q = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    wb(i, 1'b1, d, 4'hf);
  endtask

  task automatic rd(input logic [11:0] i, input string nm, input logic [31:0] e);
    wb(i, 1'b0, 8'h00, 4'hf);
    chk(nm, q, e);
  endtask

  // excluded pins drop out: ones for nand, zeros for nor
  function automatic logic gexp(input logic [2:0] c, input logic pol, input swr_pins_s p,
      input swr_pins_s x);
    swr_pins_s a;
    swr_pins_s o;
    logic g;
    a = p | x;
    o = p & ~x;
    case (c)
      3'd1: g = ~&a.p2[3:0];
      3'd2: g = ~&a.p2;
      3'd3: g = ~|o.p3[3:1];
      3'd4: g = ~&a.p3[3:1];
      3'd5: g = ~|{o.p3[3:1], o.p0[0], o.p0[7]};
      3'd6: g = ~&{a.p3[3:1], a.p0[0], a.p0[7]};
      default: return 1'b0;
    endcase
    return pol ? g : ~g;
  endfunction

  task automatic gcase(input logic [2:0] c, input logic pol, input swr_pins_s p,
      input swr_pins_s oe, input swr_pins_s fs);
    pm.set_pins(p);
    oen <= oe;
    fsel <= fs;
    wr(`SWR_IDX_GATESEL, {1'b0, pol, 1'b1, c, 2'b11});
    repeat (6) @(posedge clk_i);
    wr(`SWR_IDX_EVT, 8'h03);
    repeat (6) @(posedge clk_i);
    rd(`SWR_IDX_EVT, "gate_evt", {31'h0, gexp(c, pol, p, oe | fs)});
  endtask

  task automatic p3evt(input swr_pins_s p, input logic [31:0] e);
    pm.set_pins(p);
    repeat (6) @(posedge clk_i);
    wr(`SWR_IDX_EVT, 8'h03);
    repeat (6) @(posedge clk_i);
    rd(`SWR_IDX_EVT, "p3_evt", e);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end

  initial begin
    {we, cyc, stb, sel, adr, wdat} = '0;
    oen = '0;
    fsel = '0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SWR_IDX_STATUS, "status_rst", 32'h0);
    rd(12'h123, "unmapped", 32'h0);
    chk("wake_rst", {31'h0, wake}, 32'h0);
    wr(`SWR_IDX_P3SEL, 8'hf1);
    p3evt(24'hfffff1, 32'h0);
    chk("wake", {31'h0, wake}, 32'h0);
    p3evt(24'hfffff0, 32'h2);
    chk("wake_any", {31'h0, wake}, 32'h1);
    pm.access(1'b1, 1'b1, 8'h00);
    rd(`SWR_IDX_STATUS, "st_p3wr", 32'h08);
    p3evt(24'hfffff0, 32'h0);
    p3evt(24'hfffff1, 32'h2);
    pm.access(1'b1, 1'b0, 8'h01);
    rd(`SWR_IDX_STATUS, "st_p3rd", 32'h04);
    p3evt(24'hfffff1, 32'h0);
    wr(`SWR_IDX_STATUS, 8'h00);
    p3evt(24'hfffff1, 32'h0);
    p3evt(24'hfffff0, 32'h2);
    wr(`SWR_IDX_MASK, 8'h02);
    repeat (2) @(posedge clk_i);
    chk("irq_off", {31'h0, irq}, 32'h0);
    wr(`SWR_IDX_STATUS, 8'h10);
    repeat (2) @(posedge clk_i);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wb(`SWR_IDX_MASK, 1'b1, 8'h00, 4'he);
    rd(`SWR_IDX_MASK, "mask_sel", 32'h2);
    wr(`SWR_IDX_MASK, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    rd(`SWR_IDX_P3SEL, "wo_read", 32'h0);
    pm.access(1'b0, 1'b0, 8'h5a);
    rd(`SWR_IDX_STATUS, "st_p2rd", 32'h11);
    pm.access(1'b0, 1'b1, 8'ha5);
    rd(`SWR_IDX_STATUS, "st_p2wr", 32'h12);
    wr(`SWR_IDX_P3SEL, 8'hf0);
    for (int c = 0; c < 8; c++) begin
      for (int pl = 0; pl < 2; pl++) begin
        foreach (pat[i]) begin
          gcase(3'(c), 1'(pl), pat[i], '0, '0);
        end
      end
    end
    gcase(3'd4, 1'b0, 24'hfffffd, '0, 24'h000002);
    gcase(3'd5, 1'b1, 24'h80fef1, 24'h800000, '0);
    close_out();
  end
endmodule
